// [bieg_defs.vh]
// Purpose: constants for the block interrupt enable gate
// Assumes: 32-bit AXI4-Lite register bus, byte addressing of index*4
// Notes:   definitions only
`ifndef BIEG_DEFS_VH
`define BIEG_DEFS_VH

// --------------------------------------------------------------
// register indices and byte addresses
// --------------------------------------------------------------
`define BIEG_IDX_ENABLE      16'h0B01
`define BIEG_IDX_PENDING     16'h0B00
`define BIEG_IDX_IRQ_STAT    16'h0B80
`define BIEG_IDX_IRQ_MASK    16'h0B81
`define BIEG_ADDR_ENABLE     18'h02C04
`define BIEG_ADDR_PENDING    18'h02C00
`define BIEG_ADDR_IRQ_STAT   18'h02E00
`define BIEG_ADDR_IRQ_MASK   18'h02E04

// --------------------------------------------------------------
// enable register field positions
// --------------------------------------------------------------
`define BIEG_BIT_FRAMER      0
`define BIEG_BIT_ALARM       1
`define BIEG_BIT_SLIP        2
`define BIEG_BIT_HDLC        3
`define BIEG_BIT_ONESEC      4
`define BIEG_BIT_CLKLOSS     5
`define BIEG_BIT_LOOPCODE    6
`define BIEG_BIT_RSVD        7
`define BIEG_ENABLE_MASK     8'h7F

// --------------------------------------------------------------
// reset values and bus answers
// --------------------------------------------------------------
`define BIEG_ENABLE_RST      8'h00
`define BIEG_MASK_RST        8'h00
`define BIEG_RESP_OKAY       2'h0
`define BIEG_RESP_SLVERR     2'h2

`endif

// [bieg_pend.v]
// Purpose: per-block pending flags, cleared by the source status read
// Assumes: request and clear strobes on mclk
// Notes:   a request in the clear cycle keeps the flag set
`timescale 1ns/100ps
module bieg_pend #(
   parameter N = 7
) (
   input  wire         mclk,
   input  wire         rst,
   input  wire [N-1:0] req,
   input  wire [N-1:0] src_read,
   output reg  [N-1:0] pend_q
);
   // --------------------------------------------------------------
   // one flag per block
   // --------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_pend
         // set wins over clear
         always @(posedge mclk) begin
            if (rst)
               pend_q[i] <= 1'b0;
            else if (req[i])
               pend_q[i] <= 1'b1;
            else if (src_read[i])
               pend_q[i] <= 1'b0; // see R8
         end
      end
   endgenerate
endmodule // bieg_pend

// [bieg_top.v]
// Purpose: block interrupt enable gate with AXI4-Lite registers
// Assumes: mclk 10 MHz, rst synchronous active high
// Notes:   pending lines come from source blocks; one level irq out
//
// Functional notes
// R1: bit 6 gates loopback-code block, reset zero
// R2: bit 5 enables recovered-clock-loss, reset zero
// R3: bit 4 enables one-second tick, reset zero
// R4: bit 3 gates HDLC block, reset zero
// R5: bit 2 gates slip-buffer block, reset zero
// R6: bit 1 gates alarm-error block, reset zero
// R7: bit 0 gates framer block, reset zero
// R8: pending clears after source status read
// R9: bit 7 reads zero, writes ignored
`timescale 1ns/100ps
`include "bieg_defs.vh"
module bieg_top (
   input  wire        mclk,
   input  wire        rst,
   // source side: requests already gated by source-level enables
   input  wire [6:0]  src_req,
   input  wire [6:0]  src_status_read,
   // axi4-lite slave
   input  wire [17:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [17:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // gated requests and interrupt pin
   output reg  [6:0]  irq_req_q,
   output reg         irq_q
);
   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   reg  [7:0]  enable_q;
   reg  [7:0]  mask_q;
   reg  [7:0]  stat_q;
   reg         aw_have_q;
   reg         w_have_q;
   reg  [17:0] awaddr_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;
   wire [6:0]  pend;
   wire [6:0]  gated;
   wire        wr_go;
   wire        rd_go;
   wire        rd_stat;
   reg  [31:0] rd_d;
   reg  [1:0]  rresp_d;

   // --------------------------------------------------------------
   // pending flags per block
   // --------------------------------------------------------------
   bieg_pend #(
      .N        (7)
   ) u_pend (
      .mclk     (mclk),
      .rst      (rst),
      .req      (src_req),
      .src_read (src_status_read),
      .pend_q   (pend)
   );

   // block enables gate pending flags toward the pin
   assign gated[`BIEG_BIT_FRAMER]   = pend[`BIEG_BIT_FRAMER]
                                      & enable_q[`BIEG_BIT_FRAMER];   // see R7
   assign gated[`BIEG_BIT_ALARM]    = pend[`BIEG_BIT_ALARM]
                                      & enable_q[`BIEG_BIT_ALARM];    // see R6
   assign gated[`BIEG_BIT_SLIP]     = pend[`BIEG_BIT_SLIP]
                                      & enable_q[`BIEG_BIT_SLIP];     // see R5
   assign gated[`BIEG_BIT_HDLC]     = pend[`BIEG_BIT_HDLC]
                                      & enable_q[`BIEG_BIT_HDLC];     // see R4
   assign gated[`BIEG_BIT_ONESEC]   = pend[`BIEG_BIT_ONESEC]
                                      & enable_q[`BIEG_BIT_ONESEC];   // see R3
   assign gated[`BIEG_BIT_CLKLOSS]  = pend[`BIEG_BIT_CLKLOSS]
                                      & enable_q[`BIEG_BIT_CLKLOSS];  // see R2
   assign gated[`BIEG_BIT_LOOPCODE] = pend[`BIEG_BIT_LOOPCODE]
                                      & enable_q[`BIEG_BIT_LOOPCODE]; // see R1

   // --------------------------------------------------------------
   // write channel
   // --------------------------------------------------------------
   assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;

   // capture address and data in either order
   always @(posedge mclk) begin
      if (rst) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= 18'h00000;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid & ~aw_have_q & ~s_axi_awready) begin
            s_axi_awready <= 1'b1;
            aw_have_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
         end
         if (s_axi_wvalid & ~w_have_q & ~s_axi_wready) begin
            s_axi_wready <= 1'b1;
            w_have_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
         end
      end
   end

   // register writes and write response
   always @(posedge mclk) begin
      if (rst) begin
         enable_q     <= `BIEG_ENABLE_RST; // see R1
         mask_q       <= `BIEG_MASK_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `BIEG_RESP_OKAY;
      end else begin
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `BIEG_RESP_OKAY;
            if (awaddr_q[17:2] == `BIEG_IDX_ENABLE) begin
               if (wstrb_q[0])
                  enable_q <= wdata_q[7:0]
                              & `BIEG_ENABLE_MASK; // see R9
            end else if (awaddr_q[17:2] == `BIEG_IDX_IRQ_MASK) begin
               if (wstrb_q[0])
                  mask_q <= wdata_q[7:0] & `BIEG_ENABLE_MASK;
            end else if ((awaddr_q[17:2] != `BIEG_IDX_PENDING) &&
                         (awaddr_q[17:2] != `BIEG_IDX_IRQ_STAT))
               s_axi_bresp <= `BIEG_RESP_SLVERR;
         end
      end
   end

   // --------------------------------------------------------------
   // read channel
   // --------------------------------------------------------------
   assign rd_go   = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
   assign rd_stat = rd_go & (s_axi_araddr[17:2] == `BIEG_IDX_IRQ_STAT);

   // read data mux
   always @* begin
      rd_d    = 32'h00000000;
      rresp_d = `BIEG_RESP_OKAY;
      case (s_axi_araddr[17:2])
         `BIEG_IDX_ENABLE:   rd_d[7:0] = enable_q; // see R9
         `BIEG_IDX_PENDING:  rd_d[6:0] = pend;
         `BIEG_IDX_IRQ_STAT: rd_d[7:0] = stat_q;
         `BIEG_IDX_IRQ_MASK: rd_d[7:0] = mask_q;
         default:            rresp_d   = `BIEG_RESP_SLVERR;
      endcase
   end

   // one read at a time, answer next cycle
   always @(posedge mclk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `BIEG_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (rd_go) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_d;
            s_axi_rresp   <= rresp_d;
         end
      end
   end

   // --------------------------------------------------------------
   // sticky status, mask and interrupt pin
   // --------------------------------------------------------------
   // rising gated request sets sticky bit; set wins over read clear
   always @(posedge mclk) begin
      if (rst) begin
         stat_q    <= 8'h00;
         irq_req_q <= 7'h00;
         irq_q     <= 1'b0;
      end else begin
         irq_req_q <= gated;
         stat_q    <= ((rd_stat ? 8'h00 : stat_q)
                      | {1'b0, gated & ~irq_req_q});
         irq_q     <= |(stat_q & mask_q);
      end
   end
endmodule // bieg_top

// [bieg_top_assertions.sv]
// Purpose: port assertions for the block interrupt enable gate
// Assumes: one clock mclk, rst synchronous active high
// Notes:   bound to bieg_top from the bench
`timescale 1ns/100ps
module bieg_chk (
   input logic        mclk,
   input logic        rst,
   input logic [6:0]  src_req,
   input logic [6:0]  src_status_read,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic [31:0] s_axi_rdata,
   input logic [6:0]  irq_req_q,
   input logic        irq_q
);
   // -------------------------------------------------------
   // helpers and assertions
   // -------------------------------------------------------
   logic [6:0] clr_q, clr2_q;
   logic       wr_seen_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // cleared flags two cycles back, any write answered
   always_ff @(posedge mclk) begin
      clr_q     <= rst ? 7'h00 : src_status_read & ~src_req;
      clr2_q    <= rst ? 7'h00 : clr_q & ~src_req;
      wr_seen_q <= !rst && (wr_seen_q || s_axi_bvalid);
   end
   chk_rst_quiet: assert property ($fell(rst) |-> !irq_q && !irq_req_q)
      else $error("outputs not quiet after reset");
   chk_gate_closed: assert property (!wr_seen_q |-> irq_req_q == 7'h00)
      else $error("gated request before any enable write");
   chk_aw_ready: assert property ($rose(s_axi_awvalid) |=> s_axi_awready)
      else $error("write address not taken in time");
   chk_b_timing: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   chk_r_timing: assert property ($rose(s_axi_arvalid) |=> s_axi_rvalid)
      else $error("read answer late");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
      else $error("upper read bits set");
   chk_pend_clear: assert property ((irq_req_q & clr2_q) == 7'h00)
      else $error("request survives status read");
   chk_irq_cause: assert property ($rose(irq_q) |->
      $past(s_axi_bvalid) || $past(irq_req_q) != 7'h00)
      else $error("interrupt without cause");
endmodule // bieg_chk

// [bieg_top_tb.sv]
// Purpose: self-checking bench for the block interrupt enable gate
// Assumes: mclk 10 MHz, rst synchronous active high
// Notes:   row table first, then refusal, irq and reset cases
`timescale 1ns/100ps
`include "bieg_defs.vh"
module bieg_top_tb;
   logic        mclk = 1'b0, rst = 1'b1;
   logic [6:0]  src_req = 7'h00, src_status_read = 7'h00;
   logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
   logic [31:0] s_axi_wdata = 32'h0, d;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic [1:0]  r;
   logic [21:0] rows [10];
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, irq_q;
   wire         s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [6:0]  irq_req_q;
   int          n_fail = 0, samples_checked = 0, cyc = 0, i;
   bieg_top uut (.mclk(mclk), .rst(rst), .src_req(src_req),
      .src_status_read(src_status_read), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .irq_req_q(irq_req_q), .irq_q(irq_q));
   // -------------------------------------------------------
   // clock, watchdog and tasks
   // -------------------------------------------------------
   always #50 mclk = ~mclk;
   // cut a hang short
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         results();
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [17:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask
   task rd(input logic [17:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask
   task pulse_req(input logic [6:0] v, input int n);
      src_req <= v;
      @(posedge mclk);
      src_req <= 7'h00;
      repeat (n) @(posedge mclk);
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // rows: enable written, request, gated request expected
   initial begin
      rows = '{{8'hFF, 7'h7F, 7'h7F}, {8'h40, 7'h7F, 7'h40},
         {8'h20, 7'h7F, 7'h20}, {8'h10, 7'h7F, 7'h10},
         {8'h08, 7'h7F, 7'h08}, {8'h04, 7'h7F, 7'h04},
         {8'h02, 7'h7F, 7'h02}, {8'h01, 7'h7F, 7'h01},
         {8'h80, 7'h7F, 7'h00}, {8'hAA, 7'h55, 7'h00}};
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (i = 0; i < 10; i++) begin
         wr(`BIEG_ADDR_ENABLE, 32'(rows[i][21:14]));
         rd(`BIEG_ADDR_ENABLE);
         chk(d, 32'(rows[i][20:14]));
         pulse_req(rows[i][13:7], 2);
         chk(32'(irq_req_q), 32'(rows[i][6:0]));
         src_status_read <= 7'h7F;
         @(posedge mclk);
         src_status_read <= 7'h00;
         repeat (2) @(posedge mclk);
         chk(32'(irq_req_q), 32'h0);
      end
      // unmapped read is refused
      rd(18'h00100);
      chk(32'(r), 32'(`BIEG_RESP_SLVERR));
      // unmapped write is refused, read-only view takes write quietly
      wr(18'h00100, 32'h7F);
      chk(32'(r), 32'(`BIEG_RESP_SLVERR));
      wr(`BIEG_ADDR_PENDING, 32'h7F);
      chk(32'(r), 32'(`BIEG_RESP_OKAY));
      rd(`BIEG_ADDR_PENDING);
      chk(d, 32'h0);
      // interrupt raised, read-cleared, then other block gated off
      rd(`BIEG_ADDR_IRQ_STAT);
      wr(`BIEG_ADDR_IRQ_MASK, 32'h84);
      chk(32'(r), 32'(`BIEG_RESP_OKAY));
      rd(`BIEG_ADDR_IRQ_MASK);
      chk(d, 32'h4);
      wr(`BIEG_ADDR_ENABLE, 32'h4);
      pulse_req(7'h04, 3);
      chk(32'(irq_q), 32'h1);
      rd(`BIEG_ADDR_IRQ_STAT);
      chk(d, 32'h4);
      repeat (2) @(posedge mclk);
      chk(32'(irq_q), 32'h0);
      pulse_req(7'h01, 3);
      chk(32'(irq_req_q), 32'h4);
      // reset in mid-run clears the enables
      rst <= 1'b1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(`BIEG_ADDR_ENABLE);
      chk(d, 32'h0);
      results();
   end
endmodule // bieg_top_tb
bind bieg_top bieg_chk u_chk (.mclk(mclk), .rst(rst), .src_req(src_req),
   .src_status_read(src_status_read), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .irq_req_q(irq_req_q), .irq_q(irq_q));
